/* File: hdl/bls_top.sv */
`timescale 1ns/10ps
module bls_top
    import bls_pkg::*;
#(
    parameter int          NCH          = 8,
    parameter logic [6:0]  SMB_ADDR     = 7'h2C,  // arbitrary neutral value
    parameter int          RESTART_CYCS = bls_pkg::RESTART_CYC
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_n_o,
    input  wire logic             enable_i,
    input  wire logic [1:0]       interface_select_pin_a_i,
    input  wire logic [1:0]       interface_select_pin_b_i,
    input  wire logic [7:0]       pwm_duty_i,
    input  wire logic             pwm_duty_vld_i,
    input  wire logic             boost_pwm_i,
    input  wire logic             cycle_start_i,
    input  wire logic             cycle_ilim_i,
    input  wire logic             out_ov_i,
    input  wire logic             out_below_clamp_i,
    input  wire logic             ocp_sustained_i,
    input  wire logic             out_short_i,
    input  wire logic             thermal_trip_i,
    input  wire logic [NCH-1:0]   string_channel_nocurr_i,
    input  wire logic [NCH-1:0]   string_channel_ov_i,
    output logic                  boost_gate_o,
    output logic [NCH-1:0]        sink_en_o,
    output logic [NCH-1:0]        loop_mask_o,
    output logic [7:0]            sink_level_o,
    output logic [7:0]            dim_duty_o,
    output bls_pkg::bls_dim_e     dim_mode_o,
    output logic                  smbus_sel_o
);
    import bls_pkg::*;

    // scl, sda, enable, two 2-bit straps, eight single levels, two channel vectors
    localparam int AW = 15 + 2 * NCH;

    ////////////////////////////////////////////////////////////////////////
    // link side: sda sampled on the host's own clock rise; the core reads
    // it only after it has seen that rise through its synchroniser, so the
    // value is long settled and needs no reset
    logic sda_cap_q;
    always_ff @(posedge scl_i) begin
        sda_cap_q <= sda_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser for every asynchronous input
    logic [AW-1:0] async_w;
    logic [AW-1:0] sy1_q;
    logic [AW-1:0] sy2_q;
    assign async_w = {scl_i, sda_i, enable_i, interface_select_pin_a_i,
                      interface_select_pin_b_i, boost_pwm_i, cycle_start_i,
                      cycle_ilim_i, out_ov_i, out_below_clamp_i, ocp_sustained_i,
                      out_short_i, thermal_trip_i, string_channel_nocurr_i,
                      string_channel_ov_i};
    always_ff @(posedge clk_i) begin
        sy1_q <= async_w;
        sy2_q <= sy1_q;
    end

    logic           scl_s, sda_s, en_s, bpwm_s, cyc_s, ilim_s, ov_s, blw_s;
    logic           ocp_s, shrt_s, therm_s;
    logic [1:0]     sela_s, selb_s;
    logic [NCH-1:0] nocur_s, chov_s;
    assign {scl_s, sda_s, en_s, sela_s, selb_s, bpwm_s, cyc_s, ilim_s, ov_s,
            blw_s, ocp_s, shrt_s, therm_s, nocur_s, chov_s} = sy2_q;

    logic scl_d1_q, sda_d1_q, cyc_d1_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_d1_q <= 1'b1;
            sda_d1_q <= 1'b1;
            cyc_d1_q <= 1'b0;
        end else begin
            scl_d1_q <= scl_s;
            sda_d1_q <= sda_s;
            cyc_d1_q <= cyc_s;
        end
    end
    logic scl_rise, scl_fall, smb_start, smb_stop, cyc_rise;
    assign scl_rise  = scl_s & ~scl_d1_q;
    assign scl_fall  = ~scl_s & scl_d1_q;
    assign smb_start = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
    assign smb_stop  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
    assign cyc_rise  = cyc_s & ~cyc_d1_q;

    ////////////////////////////////////////////////////////////////////////
    // strap decode
    bls_dim_e dim_mode;
    logic     smb_en;
    always_comb begin
        dim_mode = DIM_DIRECT;
        smb_en   = 1'b0;
        if (sela_s == PIN_VDD && selb_s == PIN_GND) begin
            dim_mode = DIM_NODELAY;
            smb_en   = 1'b1;
        end else if (sela_s == PIN_OPEN && selb_s == PIN_GND) begin
            dim_mode = DIM_NODELAY;
        end else if (sela_s == PIN_GND && selb_s == PIN_VDD) begin
            dim_mode = DIM_ANALOG;
            smb_en   = 1'b1;
        end else if (sela_s == PIN_GND && selb_s == PIN_OPEN) begin
            dim_mode = DIM_ANALOG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // smbus slave
    bls_smb_e   st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] cmd_q;
    logic       ack_q;
    logic       rd_q;
    logic       drv_q;
    logic [7:0] rd_byte;
    logic       byte_done;
    logic       wr_stb;

    assign byte_done = scl_fall & ~ack_q & (bit_q == BITS_PER_BYTE);
    assign wr_stb    = byte_done & (st_q == SM_WDATA);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q  <= SM_IDLE;
            bit_q <= BIT_ZERO;
            sh_q  <= BYTE_ZERO;
            cmd_q <= BYTE_ZERO;
            ack_q <= 1'b0;
            rd_q  <= 1'b0;
            drv_q <= 1'b0;
        end else if (smb_stop || !smb_en) begin
            st_q  <= SM_IDLE;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
        end else if (smb_start) begin
            st_q  <= SM_ADDR;
            bit_q <= BIT_ZERO;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
        end else begin
            unique case (st_q)
                SM_IDLE, SM_SKIP: begin
                    drv_q <= 1'b0;
                end
                SM_ADDR, SM_CMD, SM_WDATA: begin
                    if (scl_rise && !ack_q) begin
                        sh_q  <= {sh_q[6:0], sda_cap_q};
                        bit_q <= bit_q + BIT_ONE;
                    end else if (byte_done) begin
                        if (st_q == SM_ADDR && sh_q[7:1] != SMB_ADDR) begin
                            st_q <= SM_SKIP;
                        end else begin
                            ack_q <= 1'b1;
                            drv_q <= 1'b1;
                            if (st_q == SM_ADDR) begin
                                rd_q <= sh_q[0];
                            end
                            if (st_q == SM_CMD) begin
                                cmd_q <= sh_q;
                            end
                        end
                    end else if (scl_fall && ack_q) begin
                        ack_q <= 1'b0;
                        bit_q <= BIT_ZERO;
                        drv_q <= 1'b0;
                        if (st_q == SM_ADDR && rd_q) begin
                            st_q  <= SM_RDATA;
                            sh_q  <= rd_byte;
                            drv_q <= ~rd_byte[7];
                        end else if (st_q == SM_ADDR) begin
                            st_q <= SM_CMD;
                        end else if (st_q == SM_CMD) begin
                            st_q <= SM_WDATA;
                        end else begin
                            st_q <= SM_SKIP;
                        end
                    end
                end
                SM_RDATA: begin
                    if (scl_rise) begin
                        bit_q <= bit_q + BIT_ONE;
                        if (bit_q == BITS_PER_BYTE) begin
                            st_q <= SM_SKIP;
                        end
                    end else if (scl_fall) begin
                        if (bit_q < BITS_PER_BYTE) begin
                            sh_q  <= {sh_q[6:0], 1'b0};
                            drv_q <= ~sh_q[6];
                        end else begin
                            drv_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    st_q <= SM_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protection
    logic [NCH-1:0] ch_off_q;
    logic           ocp_lat_q, short_lat_q, ov_off_q, ilim_off_q, en_d1_q;
    logic [$clog2(RESTART_CYCS+1)-1:0] rst_cnt_q;
    logic           ctl_wr, all_open, restart, run;

    assign ctl_wr   = wr_stb & (cmd_q == REG_CONTROL);
    assign all_open = &ch_off_q;
    assign restart  = all_open && (rst_cnt_q == RESTART_CYCS[$bits(rst_cnt_q)-1:0]);
    assign run      = en_s & ~therm_s & ~ocp_lat_q & ~short_lat_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rst_cnt_q <= '0;
        end else if (all_open && !restart) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end else begin
            rst_cnt_q <= '0;
        end
    end

    // a new fault wins over any reactivation arriving in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ch_off_q <= '0;
        end else if (!en_s) begin
            ch_off_q <= '0;
        end else begin
            ch_off_q <= ((ctl_wr || restart) ? '0 : ch_off_q)
                      | (run ? (nocur_s | chov_s) : '0);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ocp_lat_q   <= 1'b0;
            short_lat_q <= 1'b0;
            en_d1_q     <= 1'b0;
        end else begin
            en_d1_q     <= en_s;
            ocp_lat_q   <= en_s & (ocp_lat_q | ocp_s);
            short_lat_q <= en_s & ((short_lat_q & ~ctl_wr) | shrt_s);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ov_off_q   <= 1'b0;
            ilim_off_q <= 1'b0;
        end else begin
            ov_off_q   <= ov_s | (ov_off_q & ~blw_s);
            ilim_off_q <= ilim_s | (ilim_off_q & ~cyc_rise);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] brt_q;
    logic [2:0] ctl_q;
    logic [7:0] status;
    logic [1:0] fcnt;
    logic [$clog2(NCH+1)-1:0] noff;

    always_comb begin
        noff = '0;
        for (int i = 0; i < NCH; i++) begin
            noff = noff + {{($bits(noff)-1){1'b0}}, ch_off_q[i]};
        end
    end
    assign fcnt = (noff == '0) ? CNT_NONE :
                  (noff == {{($bits(noff)-1){1'b0}}, 1'b1}) ? CNT_ONE : CNT_MANY;

    always_comb begin
        status               = STATUS_RST;
        status[ST_CNT_HI]    = fcnt[1];
        status[ST_CNT_LO]    = fcnt[0];
        status[ST_SINKS_ON]  = ctl_q[CTL_SINKS_ON] & run;
        status[ST_OVERCURR]  = ocp_lat_q;
        status[ST_THERMAL]   = therm_s;
        status[ST_ANY_FAULT] = ocp_lat_q | therm_s | short_lat_q;
    end

    always_comb begin
        unique case (cmd_q)
            REG_BRIGHTNESS: rd_byte = brt_q;
            REG_CONTROL:    rd_byte = {5'h00, ctl_q};
            REG_STATUS:     rd_byte = status;
            default:        rd_byte = BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            brt_q <= BRIGHTNESS_RST;
            ctl_q <= CONTROL_RST[2:0];
        end else begin
            if (!smb_en && pwm_duty_vld_i) begin
                brt_q <= pwm_duty_i;
            end else if (wr_stb && cmd_q == REG_BRIGHTNESS) begin
                brt_q <= sh_q;
            end
            if (ctl_wr) begin
                ctl_q <= sh_q[2:0] & CTL_WR_MASK[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // brightness source and outputs
    logic [15:0] prod;
    logic [7:0]  eff;
    assign prod = brt_q * pwm_duty_i + {8'h00, brt_q};
    always_comb begin
        if (!smb_en) begin
            eff = brt_q;
        end else if (ctl_q[CTL_PWM_SRC]) begin
            eff = pwm_duty_i;
        end else if (ctl_q[CTL_ABS_MODE]) begin
            eff = brt_q;
        end else begin
            eff = prod[15:8];
        end
    end

    logic sinks_on;
    assign sinks_on = (smb_en ? ctl_q[CTL_SINKS_ON] : 1'b1) & run;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sda_o        <= 1'b0;
            sda_oe_n_o   <= 1'b1;
            boost_gate_o <= 1'b0;
            sink_en_o    <= '0;
            loop_mask_o  <= '0;
            sink_level_o <= BYTE_ZERO;
            dim_duty_o   <= BYTE_ZERO;
            dim_mode_o   <= DIM_DIRECT;
            smbus_sel_o  <= 1'b0;
        end else begin
            sda_o        <= 1'b0;
            sda_oe_n_o   <= ~drv_q;
            boost_gate_o <= bpwm_s & run & ~ov_off_q & ~ilim_off_q
                          & ~ov_s & ~ilim_s;
            sink_en_o    <= sinks_on ? ~ch_off_q : '0;
            loop_mask_o  <= run ? ~ch_off_q : '0;
            sink_level_o <= (dim_mode == DIM_ANALOG) ? eff : BRIGHTNESS_RST;
            dim_duty_o   <= eff;
            dim_mode_o   <= dim_mode;
            smbus_sel_o  <= smb_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_ov_gate_off: assert property (ov_s |=> !boost_gate_o)
        else $error("boost switch on during output over-voltage");
    a_ov_hold: assert property (ov_off_q && !blw_s |=> !boost_gate_o)
        else $error("boost switch released before output fell below clamp");
    a_ilim_hold: assert property (ilim_s ##1 !cyc_rise[*2] |=> !boost_gate_o)
        else $error("switch on again within the limited cycle");
    a_thermal_off: assert property (therm_s |=> (sink_en_o == '0) && !boost_gate_o)
        else $error("thermal trip did not shut down");
    a_ocp_latch: assert property (en_s && ocp_lat_q |=> ocp_lat_q)
        else $error("over-current shutdown released without enable toggle");
    a_short_latch: assert property (en_s && short_lat_q && !ctl_wr |=> short_lat_q)
        else $error("short shutdown released without reactivation");
    a_string_off: assert property (run && nocur_s[0] |=> ch_off_q[0] ##1 !sink_en_o[0])
        else $error("open string still enabled");
    a_fault_count: assert property ($countones(ch_off_q) > 1 |-> fcnt == CNT_MANY)
        else $error("faulted string count wrong");
    a_status_rsvd: assert property (status[7:6] == 2'h0)
        else $error("status reserved bits not zero");
    a_smbus_gate: assert property (!smb_en |=> (st_q == SM_IDLE && !drv_q) ##1 sda_oe_n_o)
        else $error("smbus active while pwm control selected");
    a_analog_level: assert property (dim_mode == DIM_ANALOG && sinks_on
        |=> sink_level_o == $past(eff) && sink_en_o == ~$past(ch_off_q))
        else $error("analog mode level or sinks wrong");
    a_restart_all: assert property (restart |=> ch_off_q ==
        (($past(nocur_s) | $past(chov_s)) & {NCH{$past(run)}}))
        else $error("auto-restart did not clear strings");

    c_write_byte: cover property (wr_stb && cmd_q == REG_BRIGHTNESS);
    c_read_byte:  cover property (st_q == SM_RDATA && scl_fall);
    c_ctl_reactivate: cover property (ctl_wr && ch_off_q != '0);
    c_all_open:   cover property (restart);

endmodule

/* File: hdl/bls_pkg.sv */
package bls_pkg;

    // register indices carried by the command byte
    localparam logic [7:0] REG_BRIGHTNESS = 8'h00;
    localparam logic [7:0] REG_CONTROL    = 8'h01;
    localparam logic [7:0] REG_STATUS     = 8'h02;

    // reset values
    localparam logic [7:0] BRIGHTNESS_RST = 8'hFF;
    localparam logic [7:0] CONTROL_RST    = 8'h00;
    localparam logic [7:0] STATUS_RST     = 8'h00;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;

    // control register fields
    localparam int CTL_SINKS_ON = 0;
    localparam int CTL_PWM_SRC  = 1;
    localparam int CTL_ABS_MODE = 2;
    localparam logic [7:0] CTL_WR_MASK = 8'h07;

    // status register fields
    localparam int ST_ANY_FAULT = 0;
    localparam int ST_THERMAL   = 1;
    localparam int ST_OVERCURR  = 2;
    localparam int ST_SINKS_ON  = 3;
    localparam int ST_CNT_LO    = 4;
    localparam int ST_CNT_HI    = 5;
    localparam logic [1:0] CNT_NONE = 2'h0;
    localparam logic [1:0] CNT_ONE  = 2'h1;
    localparam logic [1:0] CNT_MANY = 2'h3;

    // level codes of the three-level select straps
    localparam logic [1:0] PIN_GND  = 2'h0;
    localparam logic [1:0] PIN_OPEN = 2'h1;
    localparam logic [1:0] PIN_VDD  = 2'h2;

    // smbus framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_ZERO      = 4'h0;
    localparam logic [3:0] BIT_ONE       = 4'h1;

    // time between auto-restart attempts when every string looks open
    localparam int RESTART_TIME_US = 100;
    localparam int CLK_MHZ         = 250;
    localparam int RESTART_CYC     = RESTART_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        DIM_NODELAY = 3'b001,
        DIM_ANALOG  = 3'b010,
        DIM_DIRECT  = 3'b100
    } bls_dim_e;

    typedef enum logic [5:0] {
        SM_IDLE  = 6'b000001,
        SM_ADDR  = 6'b000010,
        SM_CMD   = 6'b000100,
        SM_WDATA = 6'b001000,
        SM_RDATA = 6'b010000,
        SM_SKIP  = 6'b100000
    } bls_smb_e;

endpackage

/* File: tb/bls_host.sv */
`timescale 1ns/10ps
// smbus host; scl only moves inside a frame, sda released means pulled high
module bls_host (
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic step(input logic s, input logic c);
        @(posedge lclk_i);
        sda_o = s;
        scl_o = c;
    endtask
    task automatic bitx(input logic b, output logic s);
        step(b, 1'b0);
        step(b, 1'b1);
        s = sda_i;
        step(b, 1'b0);
    endtask
    // msb first, ninth slot is the acknowledge
    task automatic xfer(input logic [7:0] t, output logic [7:0] r, output logic k);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(t[i], s);
            r[i] = s;
        end
        bitx(1'b1, s);
        k = !s;
    endtask
    task automatic start();
        step(1'b1, scl_o);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                      output logic ok);
        logic [7:0] x;
        logic       k1, k2, k3;
        start();
        xfer({a, 1'b0}, x, k1);
        xfer(c, x, k2);
        xfer(d, x, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d,
                      output logic ok);
        logic [7:0] x;
        logic       k1, k2, k3, n;
        start();
        xfer({a, 1'b0}, x, k1);
        xfer(c, x, k2);
        start();
        xfer({a, 1'b1}, x, k3);
        xfer(8'hFF, d, n);
        stop();
        ok = k1 & k2 & k3;
    endtask
endmodule

/* File: tb/bls_top_test.sv */
`timescale 1ns/10ps
module bls_top_test;
    import bls_pkg::*;
    localparam logic [6:0] ADDR = 7'h2C;
    logic clk_i = 0, lclk = 0, rst_n_i = 0, en = 1, vld = 0, bp = 1, cs = 0, il = 0;
    logic ov = 0, bc = 0, ocp = 0, sht = 0, thr = 0, scl, sda_h, sda_o, sda_oe_n, gate, ssel;
    logic [1:0] pa = PIN_VDD, pb = PIN_GND;
    logic [7:0] duty = 8'h00, nc = 8'h00, cov = 8'h00, sen, lm, lvl, dd, d, e;
    logic ok;
    bls_dim_e dm;
    int num_errors = 0, tests_run = 0, cyc = 0, brightness_level = 255, ctl = 0, sd;
    wire sda_w = sda_h & (sda_oe_n | sda_o);
    initial forever #2 clk_i = ~clk_i;
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    bls_host u_bls_host (.lclk_i(lclk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
    bls_top #(.NCH(8), .SMB_ADDR(ADDR), .RESTART_CYCS(20)) u_bls_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n), .enable_i(en), .interface_select_pin_a_i(pa),
        .interface_select_pin_b_i(pb), .pwm_duty_i(duty), .pwm_duty_vld_i(vld),
        .boost_pwm_i(bp), .cycle_start_i(cs), .cycle_ilim_i(il), .out_ov_i(ov),
        .out_below_clamp_i(bc), .ocp_sustained_i(ocp), .out_short_i(sht),
        .thermal_trip_i(thr), .string_channel_nocurr_i(nc), .string_channel_ov_i(cov),
        .boost_gate_o(gate), .sink_en_o(sen), .loop_mask_o(lm), .sink_level_o(lvl),
        .dim_duty_o(dd), .dim_mode_o(dm), .smbus_sel_o(ssel));
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(string n, logic [7:0] x, logic [7:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic rdc(logic [7:0] c, logic [7:0] x);
        u_bls_host.rd(ADDR, c, d, ok);
        chk("ack", 8'h01, {7'h0, ok});
        chk("rdata", x, d);
    endtask
    task automatic wr(logic [7:0] c, logic [7:0] v);
        u_bls_host.wr(ADDR, c, v, ok);
        if (c == 0) brightness_level = v;
        if (c == 1) ctl = v & 8'h07;
        w(6);
    endtask
    initial begin
        sd = $urandom(41);
        w(16);
        rst_n_i = 1;
        w(4);
        rdc(REG_BRIGHTNESS, 8'hFF);
        rdc(REG_CONTROL, 8'h00);
        rdc(REG_STATUS, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(REG_BRIGHTNESS, $urandom);
            wr(REG_CONTROL, $urandom);
            rdc(REG_BRIGHTNESS, brightness_level);
            rdc(REG_CONTROL, ctl);
        end
        wr(REG_STATUS, 8'hFF);
        rdc(REG_STATUS, {4'h0, ctl[0], 3'h0});
        rdc(8'h03, 8'h00);
        u_bls_host.wr(ADDR ^ 7'h01, REG_CONTROL, 8'h00, ok);
        chk("ack", 8'h00, {7'h0, ok});
        // every mix of source and mode bits
        for (int m = 0; m < 8; m++) begin
            wr(REG_CONTROL, m);
            duty = $urandom;
            w(6);
            e = m[1] ? duty : m[2] ? brightness_level : (brightness_level * duty + brightness_level) >> 8;
            chk("dim_duty", e, dd);
        end
        wr(REG_CONTROL, 8'h01);
        chk("gate", 8'h01, {7'h0, gate});
        ov = 1;
        w(6);
        ov = 0;
        w(6);
        chk("gate", 8'h00, {7'h0, gate});
        bc = 1;
        w(6);
        chk("gate", 8'h01, {7'h0, gate});
        bc = 0;
        il = 1;
        w(2);
        il = 0;
        w(6);
        chk("gate", 8'h00, {7'h0, gate});
        cs = 1;
        w(6);
        chk("gate", 8'h01, {7'h0, gate});
        cs = 0;
        thr = 1;
        w(6);
        chk("gate", 8'h00, {7'h0, gate});
        rdc(REG_STATUS, 8'h03);
        thr = 0;
        w(6);
        rdc(REG_STATUS, 8'h08);
        ocp = 1;
        w(6);
        ocp = 0;
        rdc(REG_STATUS, 8'h05);
        en = 0;
        w(6);
        en = 1;
        w(6);
        rdc(REG_STATUS, 8'h08);
        sht = 1;
        w(6);
        sht = 0;
        rdc(REG_STATUS, 8'h01);
        wr(REG_CONTROL, 8'h01);
        rdc(REG_STATUS, 8'h08);
        nc[0] = 1;
        w(6);
        nc[0] = 0;
        chk("loop_mask", 8'hFE, lm);
        chk("sink_en0", 8'h00, {7'h0, sen[0]});
        rdc(REG_STATUS, 8'h18);
        cov[1] = 1;
        w(6);
        cov[1] = 0;
        chk("sink_en1", 8'h00, {7'h0, sen[1]});
        rdc(REG_STATUS, 8'h38);
        wr(REG_CONTROL, 8'h01);
        rdc(REG_STATUS, 8'h08);
        // every string open: restarts keep coming until one string carries current
        nc = 8'hFF;
        w(40);
        chk("loop_mask", 8'h00, lm);
        nc = 8'h7F;
        w(60);
        chk("loop_mask", 8'h80, lm);
        chk("sink_en", 8'h80, sen);
        nc = 8'h00;
        wr(REG_CONTROL, 8'h01);
        // second reset in mid-run brings the registers back to their reset values
        rst_n_i = 0;
        w(16);
        rst_n_i = 1;
        brightness_level = 255;
        ctl = 0;
        w(4);
        rdc(REG_BRIGHTNESS, 8'hFF);
        rdc(REG_CONTROL, 8'h00);
        rdc(REG_STATUS, 8'h00);
        // strap table: no-delay pwm, analog smbus, analog pwm, direct pwm
        for (int i = 0; i < 4; i++) begin
            pa = i == 0 ? PIN_OPEN : PIN_GND;
            pb = i == 1 ? PIN_VDD : i == 2 ? PIN_OPEN : PIN_GND;
            w(6);
            chk("mode", i == 0 ? DIM_NODELAY : i == 3 ? DIM_DIRECT : DIM_ANALOG, dm);
            chk("smbus_sel", i == 1, ssel);
            if (i != 1) begin
                duty = $urandom;
                vld = 1;
                w(1);
                vld = 0;
                w(6);
                brightness_level = duty;
                chk("dim_duty", duty, dd);
            end
            if (i == 2) chk("sink_level", brightness_level, lvl);
        end
        u_bls_host.wr(ADDR, REG_BRIGHTNESS, 8'h00, ok);
        chk("ack", 8'h00, {7'h0, ok});
        summarize();
    end
endmodule
